// >>> decoder_config_pkg.sv
/*
 Constants, types and helpers shared by the decoder register block and its
 clock generator. Assumes one clock, mclk at 250 MHz, standing in for the
 oscillator input.
*/
package decoder_config_pkg;

   // Register addresses and regions
   localparam logic [6:0] RAW_HEADER_MINUTE_ADDR = 7'h00;
   localparam logic [6:0] MEM_CLK_CONFIG_ADDR    = 7'h00;
   localparam logic [6:0] DECODER_LAST_ADDR      = 7'h4f;
   localparam logic [6:0] SCSI_FIRST_ADDR        = 7'h50;
   localparam logic [6:0] SCSI_LAST_ADDR         = 7'h6f;
   localparam logic [6:0] COMMON_FIRST_ADDR      = 7'h70;

   // Configuration field positions
   localparam int IRQ_POL_BIT   = 7;
   localparam int CAP_MSB       = 6;
   localparam int CAP_LSB       = 5;
   localparam int NARROW_BIT    = 4;
   localparam int DUAL_CAS_BIT  = 3;
   localparam int SUB_DIV_BIT   = 2;
   localparam int AUX_MSB       = 1;
   localparam int AUX_LSB       = 0;

   // Values after reset
   localparam logic [7:0] CONFIG_RESET   = 8'h00;
   localparam logic [7:0] HEADER_RESET   = 8'h00;
   localparam logic [7:0] READ_IDLE_DATA = 8'h00;

   // Timing: mclk period, oscillator period, derived counts
   localparam int MCLK_PERIOD_PS   = 4000;
   localparam int OSC_PERIOD_PS    = 8000;
   localparam int OSC_PERIOD_CYC   = (OSC_PERIOD_PS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
   localparam int DRAM_MIN_OSC     = 5;
   localparam int DRAM_CYCLE_CYC   = DRAM_MIN_OSC * OSC_PERIOD_CYC;
   localparam int RAS_TO_CAS_CYC   = 4;
   localparam int SUB_DIV_FAST     = 48;
   localparam int SUB_DIV_SLOW     = 32;
   localparam int SUB_HALF_FAST    = SUB_DIV_FAST * OSC_PERIOD_CYC / 2;
   localparam int SUB_HALF_SLOW    = SUB_DIV_SLOW * OSC_PERIOD_CYC / 2;

   // Aux clock output selections
   localparam logic [1:0] AUX_HIGH = 2'b00;
   localparam logic [1:0] AUX_HALF = 2'b01;
   localparam logic [1:0] AUX_FULL = 2'b10;

   typedef enum logic [3:0] {
      DR_IDLE = 4'b0001,
      DR_ROW  = 4'b0010,
      DR_COL  = 4'b0100,
      DR_PRE  = 4'b1000
   } dram_state_t;

   // Region select: decoder, scsi, common
   function automatic logic [2:0] region_of(input logic [6:0] addr);
      logic [2:0] r;
      r = 3'b000;
      if (addr <= DECODER_LAST_ADDR)
         r = 3'b001;
      else if (addr >= SCSI_FIRST_ADDR && addr <= SCSI_LAST_ADDR)
         r = 3'b010;
      else if (addr >= COMMON_FIRST_ADDR)
         r = 3'b100;
      return r;
   endfunction : region_of

   // Total capacity in Mbit for the size field
   function automatic logic [3:0] capacity_mbit(input logic [1:0] sel);
      return 4'h1 << sel;
   endfunction : capacity_mbit

endpackage : decoder_config_pkg

// >>> clock_ctrl_if.sv
/*
 Link between the register block and the clock generator: the selections
 go out, the generated clocks come back as flop outputs.
*/
`timescale 1ns/1ps
`default_nettype none
interface clock_ctrl_if;
   logic       div_sel;
   logic [1:0] aux_sel;
   logic       subcode_clk;
   logic       aux_clk;
   logic       osc_out;
   modport gen  (input div_sel, aux_sel, output subcode_clk, aux_clk, osc_out);
   modport user (output div_sel, aux_sel, input subcode_clk, aux_clk, osc_out);
endinterface : clock_ctrl_if
`default_nettype wire

// >>> clock_gen.sv
/*
 Oscillator output, subcode shift clock and aux clock output generator.
 Assumes mclk is the oscillator reference and selections are registered.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_gen
   import decoder_config_pkg::*;
(
   input  wire logic   mclk,
   input  wire logic   reset,
   clock_ctrl_if.gen   cc
);

   typedef struct packed {
      logic       osc;
      logic       half;
      logic [6:0] sub_cnt;
      logic       sub_clk;
      logic       aux;
   } clk_state_t;

   clk_state_t st_reg;
   clk_state_t st_next;

   always_comb
   begin
      logic [6:0] half_len;
      half_len = cc.div_sel ? 7'(SUB_HALF_FAST - 1) : 7'(SUB_HALF_SLOW - 1);
      st_next = st_reg;
      st_next.osc = ~st_reg.osc;
      if (!st_reg.osc)
         st_next.half = ~st_reg.half;
      if (st_reg.sub_cnt >= half_len)
      begin
         st_next.sub_cnt = 7'h00;
         st_next.sub_clk = ~st_reg.sub_clk;
      end
      else
         st_next.sub_cnt = st_reg.sub_cnt + 7'h01;
      case (cc.aux_sel)
         AUX_HALF: st_next.aux = st_next.half;
         AUX_FULL: st_next.aux = st_next.osc;
         default:  st_next.aux = 1'b1;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
         st_reg <= '{osc: 1'b0, half: 1'b0, sub_cnt: 7'h00, sub_clk: 1'b0, aux: 1'b1};
      else
         st_reg <= st_next;
   end

   assign cc.osc_out     = st_reg.osc;
   assign cc.subcode_clk = st_reg.sub_clk;
   assign cc.aux_clk     = st_reg.aux;

   // toggle after a full half period
   AST_SUB_HALF: assert property (@(posedge mclk) disable iff (reset)
      $changed(st_reg.sub_clk) && $stable(cc.div_sel) && !$past(reset)
      && $past(cc.div_sel) == $past(cc.div_sel, 2)
      |-> $past(st_reg.sub_cnt) == ($past(cc.div_sel) ? 7'(SUB_HALF_FAST - 1)
                                                      : 7'(SUB_HALF_SLOW - 1)))
      else $error("subcode clock half period wrong");

   AST_AUX_HIGH: assert property (@(posedge mclk) disable iff (reset)
      $past(cc.aux_sel) == AUX_HIGH && !$past(reset) |-> st_reg.aux)
      else $error("aux clock not held high");

endmodule : clock_gen
`default_nettype wire

// >>> decoder_config_regs.sv
/*
 Register decode, raw header minute read path, memory and clock configuration
 register, host interrupt pin, and DRAM strobe sequencer of a disc decoder.
 Assumes the sub CPU strobes arrive asynchronously; header and DRAM requests
 come from logic on mclk.
*/
// How it works
// - Addresses 00-4F decoder, 50-6F SCSI, 70-7F common block.
// - Read of 00 returns current sector's raw header minute.
// - In correction modes raw header leads buffered header by two sectors.
// - Polarity high: interrupt pin driven high active, low inactive.
// - Polarity low: pin driven low active, released when inactive.
// - Two-bit size field selects 1, 2, 4 or 8 Mbit DRAM.
// - Width bit high means 8-bit DRAM bus, low means 16-bit.
// - 16-bit bus: bit high two column strobes, low two write strobes.
// - Subcode select high: shift clock is oscillator divided by 48.
// - Subcode select low: shift clock is oscillator divided by 32.
// - Each DRAM access lasts at least five oscillator periods.
// - Refresh asserts row strobe only, never a column strobe.
// - Aux clock select: high, half oscillator, oscillator, reserved.
`timescale 1ns/1ps
`default_nettype none
module decoder_config_regs
   import decoder_config_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       reset,
   input  wire logic       cpu_cs_n,
   input  wire logic       cpu_rd_n,
   input  wire logic       cpu_wr_n,
   input  wire logic [6:0] cpu_addr,
   input  wire logic [7:0] cpu_data_in,
   output logic      [7:0] cpu_data_out,
   output logic            cpu_data_oe,
   output logic            decoder_sel,
   output logic            scsi_sel,
   output logic            common_sel,
   input  wire logic       decoder_irq_flag,
   input  wire logic       header_strobe,
   input  wire logic [7:0] header_minute,
   input  wire logic       correction_mode,
   output logic      [7:0] buffered_header_minute,
   output logic            host_irq_out,
   output logic            host_irq_oe,
   output logic      [3:0] dram_capacity_mbit,
   output logic            dram_narrow_bus,
   input  wire logic       dram_req,
   input  wire logic       dram_req_write,
   input  wire logic       dram_req_refresh,
   output logic            dram_busy,
   output logic            dram_row_strobe_n,
   output logic      [1:0] dram_column_strobe_n,
   output logic      [1:0] dram_write_strobe_n,
   output logic            subcode_shift_clock,
   output logic            aux_clock_out,
   output logic            oscillator_output
);

   typedef struct packed {
      logic [2:0]  s1_ctl;
      logic [2:0]  s2_ctl;
      logic [6:0]  s1_addr;
      logic [6:0]  s2_addr;
      logic [7:0]  s1_data;
      logic [7:0]  s2_data;
      logic        wr_prev;
      logic [7:0]  cfg;
      logic [7:0]  raw_min;
      logic [7:0]  stage_min;
      logic [7:0]  buf_min;
      logic [7:0]  data_out;
      logic        data_oe;
      logic [2:0]  region;
      logic        irq_out;
      logic        irq_oe;
      dram_state_t dstate;
      logic [3:0]  dcnt;
      logic        dwrite;
      logic        drefresh;
      logic        ras_n;
      logic [1:0]  cas_n;
      logic [1:0]  we_n;
      logic        busy;
      logic [3:0]  cap;
   } regs_state_t;

   regs_state_t st_reg;
   regs_state_t st_next;
   clock_ctrl_if cc ();

   logic cs_act;
   logic rd_act;
   logic wr_act;
   assign cs_act = ~st_reg.s2_ctl[2];
   assign rd_act = cs_act & ~st_reg.s2_ctl[1];
   assign wr_act = cs_act & ~st_reg.s2_ctl[0];

   always_comb
   begin
      logic [1:0] col_mask;
      logic [1:0] wr_mask;
      col_mask = 2'b01;
      wr_mask  = 2'b01;
      st_next = st_reg;
      st_next.s1_ctl  = {cpu_cs_n, cpu_rd_n, cpu_wr_n};
      st_next.s2_ctl  = st_reg.s1_ctl;
      st_next.s1_addr = cpu_addr;
      st_next.s2_addr = st_reg.s1_addr;
      st_next.s1_data = cpu_data_in;
      st_next.s2_data = st_reg.s1_data;
      st_next.wr_prev = wr_act;

      st_next.region = cs_act ? region_of(st_reg.s2_addr) : 3'b000;

      // fields stored for the DRAM side
      if (st_reg.wr_prev && !wr_act && st_reg.s2_addr == MEM_CLK_CONFIG_ADDR)
         st_next.cfg = st_reg.s2_data;
      st_next.cap = capacity_mbit(st_next.cfg[CAP_MSB:CAP_LSB]);

      st_next.data_oe  = rd_act && region_of(st_reg.s2_addr) == 3'b001;
      st_next.data_out = READ_IDLE_DATA;
      if (rd_act && st_reg.s2_addr == RAW_HEADER_MINUTE_ADDR)
         st_next.data_out = st_reg.raw_min;

      if (header_strobe)
      begin
         st_next.raw_min = header_minute;
         if (correction_mode)
         begin
            st_next.stage_min = st_reg.raw_min;
            st_next.buf_min   = st_reg.stage_min;
         end
      end

      if (st_reg.cfg[IRQ_POL_BIT])
      begin
         st_next.irq_out = decoder_irq_flag;
         st_next.irq_oe  = 1'b1;
      end
      else
      begin
         st_next.irq_out = 1'b0;
         st_next.irq_oe  = decoder_irq_flag;
      end

      if (!st_reg.cfg[NARROW_BIT] && st_reg.cfg[DUAL_CAS_BIT])
         col_mask = 2'b11;
      if (!st_reg.cfg[NARROW_BIT] && !st_reg.cfg[DUAL_CAS_BIT])
         wr_mask = 2'b11;

      case (st_reg.dstate)
         DR_IDLE:
         begin
            if (dram_req)
            begin
               st_next.dstate   = DR_ROW;
               st_next.dcnt     = 4'h0;
               st_next.dwrite   = dram_req_write;
               st_next.drefresh = dram_req_refresh;
               st_next.ras_n    = 1'b0;
            end
         end
         DR_ROW:
         begin
            st_next.dcnt = st_reg.dcnt + 4'h1;
            if (st_reg.dcnt == 4'(RAS_TO_CAS_CYC - 1) && !st_reg.drefresh)
            begin
               st_next.dstate = DR_COL;
               st_next.cas_n  = ~col_mask;
               if (st_reg.dwrite)
                  st_next.we_n = ~wr_mask;
            end
            else if (st_reg.dcnt == 4'(DRAM_CYCLE_CYC - 3))
            begin
               st_next.dstate = DR_PRE;
               st_next.ras_n  = 1'b1;
            end
         end
         DR_COL:
         begin
            st_next.dcnt = st_reg.dcnt + 4'h1;
            if (st_reg.dcnt == 4'(DRAM_CYCLE_CYC - 3))
            begin
               st_next.dstate = DR_PRE;
               st_next.ras_n  = 1'b1;
               st_next.cas_n  = 2'b11;
               st_next.we_n   = 2'b11;
            end
         end
         DR_PRE:
            st_next.dstate = DR_IDLE;
         default:
            st_next.dstate = DR_IDLE;
      endcase
      st_next.busy = st_next.dstate != DR_IDLE;
   end

   always_ff @(posedge mclk)
   begin
      if (reset)
      begin
         st_reg           <= '0;
         st_reg.s1_ctl    <= 3'b111;
         st_reg.s2_ctl    <= 3'b111;
         st_reg.cfg       <= CONFIG_RESET;
         st_reg.cap       <= capacity_mbit(CONFIG_RESET[CAP_MSB:CAP_LSB]);
         st_reg.raw_min   <= HEADER_RESET;
         st_reg.stage_min <= HEADER_RESET;
         st_reg.buf_min   <= HEADER_RESET;
         st_reg.dstate    <= DR_IDLE;
         st_reg.ras_n     <= 1'b1;
         st_reg.cas_n     <= 2'b11;
         st_reg.we_n      <= 2'b11;
      end
      else
         st_reg <= st_next;
   end

   assign cc.div_sel = st_reg.cfg[SUB_DIV_BIT];
   assign cc.aux_sel = st_reg.cfg[AUX_MSB:AUX_LSB];

   clock_gen clock_gen_i (
      .mclk  (mclk),
      .reset (reset),
      .cc    (cc)
   );

   assign cpu_data_out           = st_reg.data_out;
   assign cpu_data_oe            = st_reg.data_oe;
   assign decoder_sel            = st_reg.region[0];
   assign scsi_sel               = st_reg.region[1];
   assign common_sel             = st_reg.region[2];
   assign buffered_header_minute = st_reg.buf_min;
   assign host_irq_out           = st_reg.irq_out;
   assign host_irq_oe            = st_reg.irq_oe;
   assign dram_capacity_mbit     = st_reg.cap;
   assign dram_narrow_bus        = st_reg.cfg[NARROW_BIT];
   assign dram_busy              = st_reg.busy;
   assign dram_row_strobe_n      = st_reg.ras_n;
   assign dram_column_strobe_n   = st_reg.cas_n;
   assign dram_write_strobe_n    = st_reg.we_n;
   assign subcode_shift_clock    = cc.subcode_clk;
   assign aux_clock_out          = cc.aux_clk;
   assign oscillator_output      = cc.osc_out;

   // Helper: cycles since last row strobe fall
   logic [7:0] ras_gap_reg;
   always_ff @(posedge mclk)
   begin
      if (reset)
         ras_gap_reg <= 8'hff;
      else if (!dram_row_strobe_n && $past(dram_row_strobe_n))
         ras_gap_reg <= 8'h01;
      else if (ras_gap_reg != 8'hff)
         ras_gap_reg <= ras_gap_reg + 8'h01;
   end

   sequence seq_read_raw;
      rd_act && st_reg.s2_addr == RAW_HEADER_MINUTE_ADDR;
   endsequence

   sequence seq_refresh_start;
      st_reg.dstate == DR_IDLE && dram_req && dram_req_refresh;
   endsequence

   AST_REGION: assert property (@(posedge mclk) disable iff (reset)
      cs_act |=> {common_sel, scsi_sel, decoder_sel} == region_of($past(st_reg.s2_addr)))
      else $error("region select wrong");

   AST_READ_RAW: assert property (@(posedge mclk) disable iff (reset)
      seq_read_raw |=> cpu_data_oe && cpu_data_out == $past(st_reg.raw_min))
      else $error("raw minute not returned");

   AST_LEAD_TWO: assert property (@(posedge mclk) disable iff (reset)
      header_strobe && correction_mode |=> buffered_header_minute == $past(st_reg.stage_min))
      else $error("buffered header lag wrong");

   AST_IRQ_HIGH: assert property (@(posedge mclk) disable iff (reset)
      st_reg.cfg[IRQ_POL_BIT] && $stable(st_reg.cfg)
      |=> host_irq_oe && host_irq_out == $past(decoder_irq_flag))
      else $error("active high interrupt pin wrong");

   AST_IRQ_LOW: assert property (@(posedge mclk) disable iff (reset)
      !st_reg.cfg[IRQ_POL_BIT] && $stable(st_reg.cfg)
      |=> !host_irq_out && host_irq_oe == $past(decoder_irq_flag))
      else $error("active low interrupt pin wrong");

   AST_DUAL_CAS: assert property (@(posedge mclk) disable iff (reset)
      $fell(dram_column_strobe_n[0]) && !dram_narrow_bus && st_reg.cfg[DUAL_CAS_BIT]
      |-> !dram_column_strobe_n[1])
      else $error("second column strobe missing");

   AST_MIN_CYCLE: assert property (@(posedge mclk) disable iff (reset)
      $fell(dram_row_strobe_n) |-> $past(ras_gap_reg) >= 8'(DRAM_CYCLE_CYC - 1))
      else $error("DRAM access shorter than five periods");

   AST_RAS_ONLY: assert property (@(posedge mclk) disable iff (reset)
      seq_refresh_start ##1 !dram_row_strobe_n
      |-> (dram_column_strobe_n == 2'b11) [*8])
      else $error("column strobe during refresh");

   AST_CFG_SEPARATE: assert property (@(posedge mclk) disable iff (reset)
      seq_read_raw |=> cpu_data_out == $past(st_reg.raw_min) || !cpu_data_oe)
      else $error("read returned configuration");

   AST_CFG_RESET: assert property (@(posedge mclk)
      $past(reset) |-> st_reg.cfg == CONFIG_RESET)
      else $error("configuration not cleared by reset");

endmodule : decoder_config_regs
`default_nettype wire

// >>> subcpu_model.sv
/*
 Sub CPU model on the parallel register port: byte reads and writes.
 Assumes the bench calls its tasks and samples the answers they return.
*/
`timescale 1ns/1ps
`default_nettype none
module subcpu_model
(
   input  wire logic       mclk,
   output logic            cs_n,
   output logic            rd_n,
   output logic            wr_n,
   output logic      [6:0] addr,
   output logic      [7:0] wdata,
   input  wire logic [7:0] rdata,
   input  wire logic       rdata_oe,
   input  wire logic [2:0] sel
);
   initial
   begin
      cs_n  = 1'b1;
      rd_n  = 1'b1;
      wr_n  = 1'b1;
      addr  = 7'h7f;
      wdata = 8'hff;
   end

   function automatic logic div_for(input int osc_mhz);
      return osc_mhz > 32;
   endfunction : div_for

   task automatic cpu_write(input logic [6:0] a, input logic [7:0] d);
      @(posedge mclk);
      cs_n  <= 1'b0;
      wr_n  <= 1'b0;
      addr  <= a;
      wdata <= d;
      repeat (4) @(posedge mclk);
      wr_n <= 1'b1;
      repeat (2) @(posedge mclk);
      cs_n  <= 1'b1;
      addr  <= ~a;
      wdata <= ~d;
      repeat (4) @(posedge mclk);
   endtask : cpu_write

   task automatic cpu_read(input logic [6:0] a, output logic [7:0] d, output logic oe,
                           output logic [2:0] s);
      @(posedge mclk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      addr <= a;
      repeat (4) @(posedge mclk);
      #1;
      d  = rdata;
      oe = rdata_oe;
      s  = sel;
      @(posedge mclk);
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      addr <= ~a;
      repeat (4) @(posedge mclk);
   endtask : cpu_read
endmodule : subcpu_model
`default_nettype wire

// >>> decoder_config_regs_bench.sv
/*
 Self-checking bench for the decoder register block.
 Assumes the sub CPU model drives the register port; the bench drives the rest.
*/
`timescale 1ns/1ps
`default_nettype none
module decoder_config_regs_bench
   import decoder_config_pkg::*;
;
   logic       mclk, reset, cs_n, rd_n, wr_n, irq_flag, hdr_stb, corr, req, req_wr, req_rf;
   logic [6:0] addr;
   logic [7:0] wdata, hdr_min, data_out, buf_min;
   logic       data_oe, dec_sel, scsi_sel, com_sel, irq_out, irq_oe, narrow, busy;
   logic       ras_n, sub_clk, aux_clk, osc_out;
   logic [1:0] cas_n, we_n;
   logic [3:0] cap;
   int         n_fail, tests_run, cycles;

   subcpu_model subcpu_model_i (.mclk(mclk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .addr(addr), .wdata(wdata), .rdata(data_out), .rdata_oe(data_oe),
      .sel({dec_sel, scsi_sel, com_sel}));

   decoder_config_regs decoder_config_regs_i (.mclk(mclk), .reset(reset), .cpu_cs_n(cs_n),
      .cpu_rd_n(rd_n), .cpu_wr_n(wr_n), .cpu_addr(addr), .cpu_data_in(wdata),
      .cpu_data_out(data_out), .cpu_data_oe(data_oe), .decoder_sel(dec_sel),
      .scsi_sel(scsi_sel), .common_sel(com_sel), .decoder_irq_flag(irq_flag),
      .header_strobe(hdr_stb), .header_minute(hdr_min), .correction_mode(corr),
      .buffered_header_minute(buf_min), .host_irq_out(irq_out), .host_irq_oe(irq_oe),
      .dram_capacity_mbit(cap), .dram_narrow_bus(narrow), .dram_req(req),
      .dram_req_write(req_wr), .dram_req_refresh(req_rf), .dram_busy(busy),
      .dram_row_strobe_n(ras_n), .dram_column_strobe_n(cas_n), .dram_write_strobe_n(we_n),
      .subcode_shift_clock(sub_clk), .aux_clock_out(aux_clk), .oscillator_output(osc_out));

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic stop_test();
      if (n_fail == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test

   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_fail++;
         stop_test();
      end
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask : check

   task automatic restart();
      reset <= 1'b1;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1;
      check("cap", 4'h1, cap);
      check("narrow", 1'b0, narrow);
      check("irq_oe", 1'b0, irq_oe);
      check("strobes", 5'h1f, {ras_n, cas_n, we_n});
      check("aux", 1'b1, aux_clk);
   endtask : restart

   task automatic irq_set(input logic f, input logic [1:0] e);
      irq_flag <= f;
      repeat (3) @(posedge mclk);
      #1;
      check("irq pin", e, {irq_out & irq_oe, irq_oe});
   endtask : irq_set

   task automatic hdr(input logic [7:0] m);
      @(posedge mclk);
      hdr_stb <= 1'b1;
      hdr_min <= m;
      @(posedge mclk);
      hdr_stb <= 1'b0;
      hdr_min <= ~m;
   endtask : hdr

   task automatic dram_run(input logic wr, input logic rf, input logic [1:0] ecol,
                           input logic [1:0] ewr);
      int         row_lo;
      int         busy_n;
      logic [1:0] col_seen;
      logic [1:0] wr_seen;
      row_lo = 0;
      busy_n = 0;
      col_seen = 2'b00;
      wr_seen = 2'b00;
      @(posedge mclk);
      req    <= 1'b1;
      req_wr <= wr;
      req_rf <= rf;
      @(posedge mclk);
      req <= 1'b0;
      repeat (14)
      begin
         #1;
         row_lo += (ras_n === 1'b0);
         busy_n += (busy === 1'b1);
         col_seen |= ~cas_n;
         wr_seen |= ~we_n;
         @(posedge mclk);
      end
      check("row low", 8, row_lo);
      check("dram cycle", 1'b1, busy_n + 1 >= DRAM_CYCLE_CYC);
      check("column", ecol, col_seen);
      check("write", ewr, wr_seen);
   endtask : dram_run

   task automatic gap(input bit aux, output int n);
      logic prev;
      int   k;
      n = 0;
      k = 0;
      @(posedge mclk);
      #1;
      prev = aux ? aux_clk : sub_clk;
      while (k < 2 && n < 300)
      begin
         @(posedge mclk);
         #1;
         n++;
         if ((aux ? aux_clk : sub_clk) !== prev)
         begin
            k++;
            prev = ~prev;
            if (k == 1)
               n = 0;
         end
      end
   endtask : gap

   initial
   begin
      logic [6:0] ra [6];
      logic [7:0] d;
      logic       oe;
      logic [2:0] s;
      logic       dv;
      int         n;
      ra = '{7'h00, 7'h4f, 7'h50, 7'h6f, 7'h70, 7'h7f};
      {n_fail, tests_run, cycles} = '0;
      {irq_flag, hdr_stb, corr, req, req_wr, req_rf} = '0;
      hdr_min = 8'h00;
      restart();
      for (int i = 0; i < 6; i++)
      begin
         subcpu_model_i.cpu_read(ra[i], d, oe, s);
         check("region", i < 2 ? 3'b100 : (i < 4 ? 3'b010 : 3'b001), s);
         check("data oe", i < 2, oe);
         check("data", 8'h00, d);
      end
      for (int i = 0; i < 4; i++)
      begin
         subcpu_model_i.cpu_write(7'h00, {1'b0, i[1:0], i[0], 4'h0});
         check("cap", 4'h1 << i, cap);
         check("narrow", i[0], narrow);
      end
      corr <= 1'b1;
      hdr(8'h11);
      hdr(8'h22);
      hdr(8'h33);
      repeat (2) @(posedge mclk);
      check("buffered", 8'h11, buf_min);
      corr <= 1'b0;
      hdr(8'h44);
      subcpu_model_i.cpu_write(7'h00, 8'ha5);
      irq_flag <= 1'b1;
      subcpu_model_i.cpu_read(7'h00, d, oe, s);
      check("raw minute", 8'h44, d);
      check("buffered", 8'h11, buf_min);
      subcpu_model_i.cpu_write(7'h00, 8'h80);
      irq_set(1'b1, 2'b11);
      irq_set(1'b0, 2'b01);
      subcpu_model_i.cpu_write(7'h00, 8'h00);
      irq_set(1'b1, 2'b01);
      irq_set(1'b0, 2'b00);
      subcpu_model_i.cpu_write(7'h00, 8'h08);
      dram_run(1'b1, 1'b0, 2'b11, 2'b01);
      dram_run(1'b0, 1'b0, 2'b11, 2'b00);
      dram_run(1'b0, 1'b1, 2'b00, 2'b00);
      subcpu_model_i.cpu_write(7'h00, 8'h00);
      dram_run(1'b1, 1'b0, 2'b01, 2'b11);
      subcpu_model_i.cpu_write(7'h00, 8'h18);
      dram_run(1'b1, 1'b0, 2'b01, 2'b01);
      dv = subcpu_model_i.div_for(40);
      subcpu_model_i.cpu_write(7'h00, {5'h00, dv, 2'b01});
      gap(1'b0, n);
      check("subcode half", 48 * OSC_PERIOD_CYC / 2, n);
      gap(1'b1, n);
      check("aux half", OSC_PERIOD_CYC, n);
      dv = subcpu_model_i.div_for(20);
      subcpu_model_i.cpu_write(7'h00, {5'h00, dv, 2'b10});
      gap(1'b0, n);
      check("subcode half", 32 * OSC_PERIOD_CYC / 2, n);
      gap(1'b1, n);
      check("aux half", OSC_PERIOD_CYC / 2, n);
      subcpu_model_i.cpu_write(7'h00, 8'h03);
      gap(1'b1, n);
      check("aux held", 300, n);
      check("aux", 1'b1, aux_clk);
      subcpu_model_i.cpu_write(7'h00, 8'hfc);
      restart();
      stop_test();
   end
endmodule : decoder_config_regs_bench
`default_nettype wire
